/* src/ivc_top.sv */
// Purpose: Interrupt vector controller with APB register access
// Assumes: Peripheral events are one-cycle pulses on pclk; external lines are async pins
// Notes: Merged request, vector number, entry address and level go to the core
//   Read data is taken in the setup cycle
//   A push past the stack depth is dropped
// Function
// - All peripheral and external requests merge into one request to the core.
// - Each user source takes one of seven selectable priority levels.
// - Equal-level pending requests are chosen by a fixed order.
// - Lower vector position wins a tie; vector one, the first trap, outranks all others.
// - Primary table starts at 000004h with 8 trap and 118 interrupt entries.
// - Each entry holds a 24-bit handler start address.
// - Every interrupt or trap source has its own entry.
// - Alternate table select bit 15 redirects every vector fetch.
// - Alternate entries mirror the primary ones, 0x100 higher.
// - Device reset bypasses the controller; execution starts at address zero.
// - At most 20 interrupt sources and 4 traps are implemented.
// - External interrupt zero is request 0, vector 8, entry 0x000014.
// - Capture one and two, compare and timer sources use request numbers 1 to 8.
// - Serial, async and converter sources use request numbers 9 to 13.
// - Two-wire, change notify and external one, two use 16 to 29.
// - Capture channels seven and eight use requests 22 and 23.
// - Entry and return latencies are fixed, independent of the source.
// - Forwarded vector number and new level are latched into a status register.
// - Each user source has a flag set by hardware, cleared by software, and an enable.
// - Cpu level is three writable bits plus a read-only top bit.
`timescale 1ns/10ps
`default_nettype none
module ivc_top
  import ivc_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses, indexed by request number
  input wire logic [NUM_REQ-1:0] periph_irq_evt,
  // External interrupt pins
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  // Trap event pulses, bit 0 is the lowest trap vector
  input wire logic [NUM_TRAP-1:0] trap_evt,
  // Core side
  input wire logic cpu_irq_ack,
  input wire logic cpu_irq_return,
  output logic cpu_irq_req,
  output logic [VEC_W-1:0] cpu_vector_num,
  output logic [ADDR_W-1:0] cpu_vector_addr,
  output logic [CPU_LVL_W-1:0] cpu_irq_level
);

  // Pointer counts 0 to STACK_DEPTH inclusive
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  // Refuse a stack the nesting cannot live with
  if (STACK_DEPTH < 2 || STACK_DEPTH > 64) begin : g_bad_depth
    $error("ivc_top: STACK_DEPTH must be 2 to 64");
  end

  // Every request needs a vector inside the field
  if (FIRST_IRQ_VECTOR + NUM_REQ > 2 ** VEC_W) begin : g_bad_vec_span
    $error("ivc_top: request vectors overflow");
  end

  // Traps must sit below the first user vector
  if (FIRST_TRAP_VECTOR + NUM_TRAP > FIRST_IRQ_VECTOR) begin : g_bad_trap_span
    $error("ivc_top: trap vectors overlap");
  end

  // Lowest trap level must stay above every user level
  if (TRAP_LEVEL_TOP - FIRST_TRAP_VECTOR - NUM_TRAP + 1 < 2 ** LVL_W) begin : g_bad_trap_lvl
    $error("ivc_top: trap levels too low");
  end

  // A priority field must hold a level, eight fields a word
  if (PRIO_FIELD_W < LVL_W || PRIO_PER_REG * PRIO_FIELD_W > 32) begin : g_bad_prio
    $error("ivc_top: priority layout does not fit");
  end

  // Complete block state
  typedef struct packed {
    // Software-visible registers
    logic [NUM_REQ-1:0] flag;
    logic [NUM_REQ-1:0] enable;
    logic [NUM_REQ-1:0][LVL_W-1:0] prio;
    logic alt_table_select;
    logic [CPU_LVL_W-1:0] cpu_level;
    logic [NUM_TRAP-1:0] trap_flag;
    logic [VEC_W-1:0] latched_vector_number;
    logic [CPU_LVL_W-1:0] latched_new_level;

    // Nesting stack of prior levels
    logic [STACK_DEPTH-1:0][CPU_LVL_W-1:0] stack;
    logic [SP_W-1:0] sp;

    // Pin synchroniser and edge memory
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [2:0] ext_prev;

    // Bus answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;

    // Request presented to the core
    logic req;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] vaddr;
    logic [CPU_LVL_W-1:0] lvl;
  } ivc_state_t;

  ivc_state_t state_reg;
  ivc_state_t state_next;

  // Arbitration carrier and candidate selection
  ivc_arb_if #(.N(NUM_REQ)) arb_bus ();
  logic [VEC_W-1:0] cand_vec;
  logic [CPU_LVL_W-1:0] cand_lvl;
  logic cand_valid;
  logic [ADDR_W-1:0] cand_addr;
  logic trap_found;

  // Pending user requests reach the arbiter only when enabled and implemented
  // Reserved bits are masked here as well as at the flag
  always_comb begin
    arb_bus.pending = state_reg.flag & state_reg.enable & IMPL_MASK;
    arb_bus.prio = state_reg.prio;
  end

  // Highest level wins, lowest request number on a tie
  ivc_arbiter #(
    .N(NUM_REQ)
  ) u_arbiter (
    .arb(arb_bus.arb)
  );

  // Traps first, lowest trap vector wins; otherwise the user winner
  // Traps ignore enables and sit above every user level
  always_comb begin
    cand_valid = 1'b0;
    cand_vec = '0;
    cand_lvl = '0;
    trap_found = 1'b0;
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (state_reg.trap_flag[t] && !trap_found) begin
        trap_found = 1'b1;
        cand_valid = 1'b1;
        cand_vec = FIRST_TRAP_VECTOR + t[VEC_W-1:0];
        cand_lvl = TRAP_LEVEL_TOP - cand_vec[CPU_LVL_W-1:0];
      end
    end
    // User winner only while no trap is flagged
    if (!trap_found && arb_bus.win_valid) begin
      cand_valid = 1'b1;
      cand_vec = FIRST_IRQ_VECTOR + {{(VEC_W-$clog2(NUM_REQ)){1'b0}}, arb_bus.win_idx};
      cand_lvl = {1'b0, arb_bus.win_level};
    end
    // Only a level above the running one interrupts; equal does not
    if (cand_lvl <= state_reg.cpu_level) begin
      cand_valid = 1'b0;
    end
  end

  // Entry address in the table picked by the select bit
  ivc_vector_addr u_vector_addr (
    .vec_num(cand_vec),
    .alt_sel(state_reg.alt_table_select),
    .entry_addr(cand_addr)
  );

  // Next-state logic
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic [NUM_REQ-1:0] src_set;
  logic [2:0] ext_edge;
  logic [NUM_REQ-1:0] flag_clr;
  logic [NUM_TRAP-1:0] trap_clr;
  logic took_ack;
  logic [31:0] rd_word;
  logic rd_err;
  logic [1:0] prio_sel;

  always_comb begin
    state_next = state_reg;
    // Bus phases; a write lands only in the answered access cycle
    setup_phase = psel && !penable;
    access_phase = psel && penable && state_reg.pready;
    wr_access = access_phase && pwrite;
    prio_sel = 2'(paddr[4:2] - OFS_PRIO0[4:2]);
    // Nothing is cleared or read unless decoded below
    flag_clr = '0;
    trap_clr = '0;
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;

    // External pins: two flops, then rising edge
    // Only the second and third flops feed logic; the first may be metastable
    // Reset leaves all low, the idle pin level, so no false edge
    state_next.ext_s1 = {ext_irq_two, ext_irq_one, ext_irq_zero};
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.ext_prev = state_reg.ext_s2;
    ext_edge = state_reg.ext_s2 & ~state_reg.ext_prev;

    // Hardware flag sources, placed at their request numbers
    src_set = periph_irq_evt;
    src_set[REQ_EXT_IRQ_ZERO] = periph_irq_evt[REQ_EXT_IRQ_ZERO] | ext_edge[0];
    src_set[REQ_EXT_IRQ_ONE] = periph_irq_evt[REQ_EXT_IRQ_ONE] | ext_edge[1];
    src_set[REQ_EXT_IRQ_TWO] = periph_irq_evt[REQ_EXT_IRQ_TWO] | ext_edge[2];
    src_set = src_set & IMPL_MASK;

    // Register writes at the access edge
    // Unmapped or unaligned writes match nothing and change nothing
    if (wr_access) begin
      case (paddr)
        OFS_FLAG: begin
          // Write one to clear
          flag_clr = pwdata;
        end
        OFS_ENABLE: begin
          state_next.enable = pwdata & IMPL_MASK;
        end
        OFS_CONTROL: begin
          state_next.alt_table_select = pwdata[CTRL_ALT_BIT];
        end
        OFS_CPU_LEVEL: begin
          // Top bit stays with hardware so software cannot mask traps
          state_next.cpu_level[LVL_W-1:0] = pwdata[LVL_W-1:0];
        end
        OFS_TRAP: begin
          // Write one to clear
          trap_clr = pwdata[NUM_TRAP-1:0];
        end
        default: begin
          if (paddr >= OFS_PRIO0 && paddr <= OFS_PRIO3 && paddr[1:0] == 2'b00) begin
            for (int j = 0; j < PRIO_PER_REG; j++) begin
              state_next.prio[int'(prio_sel) * PRIO_PER_REG + j] = pwdata[j * PRIO_FIELD_W +: LVL_W];
            end
          end
        end
      endcase
    end

    // Sticky flags: a set in the clearing cycle survives
    // A source that fires while software clears is never lost
    state_next.flag = (state_reg.flag & ~flag_clr) | src_set;
    state_next.trap_flag = (state_reg.trap_flag & ~trap_clr) | trap_evt;

    // Read data captured in the setup cycle
    // Reads have no side effect; unused bits read as zero
    case (paddr)
      OFS_FLAG: rd_word = state_reg.flag;
      OFS_ENABLE: rd_word = state_reg.enable;
      OFS_CONTROL: rd_word[CTRL_ALT_BIT] = state_reg.alt_table_select;
      OFS_CPU_LEVEL: rd_word[CPU_LVL_W-1:0] = state_reg.cpu_level;
      OFS_TRAP: rd_word[NUM_TRAP-1:0] = state_reg.trap_flag;
      OFS_STATUS: begin
        rd_word[ST_VEC_LSB +: VEC_W] = state_reg.latched_vector_number;
        rd_word[ST_LVL_LSB +: CPU_LVL_W] = state_reg.latched_new_level;
      end
      default: begin
        if (paddr >= OFS_PRIO0 && paddr <= OFS_PRIO3 && paddr[1:0] == 2'b00) begin
          for (int j = 0; j < PRIO_PER_REG; j++) begin
            rd_word[j * PRIO_FIELD_W +: LVL_W] = state_reg.prio[int'(prio_sel) * PRIO_PER_REG + j];
          end
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase

    // Zero-wait APB answer: ready in the first access cycle
    // pslverr rides with pready; prdata holds between transfers
    state_next.pready = setup_phase;
    state_next.pslverr = setup_phase && rd_err;
    if (setup_phase) begin
      state_next.prdata = rd_err ? 32'h0000_0000 : rd_word;
    end

    // Core accepts the presented request
    // Ack wins over a same-cycle return, which is then lost
    // A full stack drops the push; the new level still applies
    took_ack = cpu_irq_ack && state_reg.req;
    if (took_ack) begin
      state_next.latched_vector_number = state_reg.vec;
      state_next.latched_new_level = state_reg.lvl;
      if (int'(state_reg.sp) < STACK_DEPTH) begin
        state_next.stack[state_reg.sp] = state_reg.cpu_level;
        state_next.sp = state_reg.sp + 1'b1;
      end
      state_next.cpu_level = state_reg.lvl;
    end else if (cpu_irq_return && state_reg.sp != '0) begin
      // Return pops; with an empty stack it is ignored
      state_next.sp = state_reg.sp - 1'b1;
      state_next.cpu_level = state_reg.stack[state_reg.sp - 1'b1];
    end

    // Presented request, registered one cycle after the decision
    // Withdrawn for a cycle after an ack or return while the level settles
    state_next.req = cand_valid && !took_ack && !cpu_irq_return;
    state_next.vec = cand_vec;
    state_next.vaddr = cand_addr;
    state_next.lvl = cand_lvl;
  end

  // State register; cleared like any register, without involving the core
  // Reset branch holds constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  // Plain copies of state bits, no logic behind a pin
  always_comb begin
    prdata = state_reg.prdata;
    pready = state_reg.pready;
    pslverr = state_reg.pslverr;
    cpu_irq_req = state_reg.req;
    cpu_vector_num = state_reg.vec;
    cpu_vector_addr = state_reg.vaddr;
    cpu_irq_level = state_reg.lvl;
  end

endmodule // ivc_top
`default_nettype wire

/* inc/ivc_pkg.sv */
// Purpose: Shared constants of the interrupt vector controller
// Assumes: One APB slave, request numbers fixed by the device variant
// Notes: Offsets are byte addresses of aligned 32-bit words
package ivc_pkg;

  // Sizes
  localparam int NUM_REQ = 32;
  localparam int NUM_TRAP = 4;
  localparam int LVL_W = 3;
  localparam int CPU_LVL_W = 4;
  localparam int VEC_W = 7;
  localparam int ADDR_W = 24;
  localparam int APB_AW = 12;
  localparam int STACK_DEPTH_DEF = 16;

  // Register offsets
  localparam logic [APB_AW-1:0] OFS_FLAG = 12'h000;
  localparam logic [APB_AW-1:0] OFS_ENABLE = 12'h004;
  localparam logic [APB_AW-1:0] OFS_PRIO0 = 12'h008;
  localparam logic [APB_AW-1:0] OFS_PRIO3 = 12'h014;
  localparam logic [APB_AW-1:0] OFS_CONTROL = 12'h018;
  localparam logic [APB_AW-1:0] OFS_CPU_LEVEL = 12'h01C;
  localparam logic [APB_AW-1:0] OFS_TRAP = 12'h020;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h024;

  // Field positions
  localparam int CTRL_ALT_BIT = 15;
  localparam int LVL_TOP_BIT = 3;
  localparam int ST_VEC_LSB = 0;
  localparam int ST_LVL_LSB = 8;
  localparam int PRIO_PER_REG = 8;
  localparam int PRIO_FIELD_W = 4;

  // Vector table layout
  localparam logic [ADDR_W-1:0] TABLE_BASE = 24'h00_0004;
  localparam logic [ADDR_W-1:0] ALT_OFFSET = 24'h00_0100;
  localparam logic [VEC_W-1:0] FIRST_IRQ_VECTOR = 7'h08;
  localparam logic [VEC_W-1:0] FIRST_TRAP_VECTOR = 7'h01;
  localparam logic [CPU_LVL_W-1:0] TRAP_LEVEL_TOP = 4'hF;

  // Request numbers
  localparam int REQ_EXT_IRQ_ZERO = 0;
  localparam int REQ_CAPTURE_CH1 = 1;
  localparam int REQ_COMPARE_CH1 = 2;
  localparam int REQ_TIMER_ONE = 3;
  localparam int REQ_CAPTURE_CH2 = 5;
  localparam int REQ_COMPARE_CH2 = 6;
  localparam int REQ_TIMER_TWO = 7;
  localparam int REQ_TIMER_THREE = 8;
  localparam int REQ_SERIAL_ERROR = 9;
  localparam int REQ_SERIAL_DONE = 10;
  localparam int REQ_ASYNC_RECEIVE = 11;
  localparam int REQ_ASYNC_TRANSMIT = 12;
  localparam int REQ_CONVERTER_DONE = 13;
  localparam int REQ_TWO_WIRE_SLAVE = 16;
  localparam int REQ_TWO_WIRE_MASTER = 17;
  localparam int REQ_CHANGE_NOTIFY = 19;
  localparam int REQ_EXT_IRQ_ONE = 20;
  localparam int REQ_CAPTURE_CH7 = 22;
  localparam int REQ_CAPTURE_CH8 = 23;
  localparam int REQ_EXT_IRQ_TWO = 29;

  // Implemented request lines; all others are reserved
  localparam logic [NUM_REQ-1:0] IMPL_MASK =
    (32'h0000_0001 << REQ_EXT_IRQ_ZERO) | (32'h0000_0001 << REQ_CAPTURE_CH1) |
    (32'h0000_0001 << REQ_COMPARE_CH1) | (32'h0000_0001 << REQ_TIMER_ONE) |
    (32'h0000_0001 << REQ_CAPTURE_CH2) | (32'h0000_0001 << REQ_COMPARE_CH2) |
    (32'h0000_0001 << REQ_TIMER_TWO) | (32'h0000_0001 << REQ_TIMER_THREE) |
    (32'h0000_0001 << REQ_SERIAL_ERROR) | (32'h0000_0001 << REQ_SERIAL_DONE) |
    (32'h0000_0001 << REQ_ASYNC_RECEIVE) | (32'h0000_0001 << REQ_ASYNC_TRANSMIT) |
    (32'h0000_0001 << REQ_CONVERTER_DONE) | (32'h0000_0001 << REQ_TWO_WIRE_SLAVE) |
    (32'h0000_0001 << REQ_TWO_WIRE_MASTER) | (32'h0000_0001 << REQ_CHANGE_NOTIFY) |
    (32'h0000_0001 << REQ_EXT_IRQ_ONE) | (32'h0000_0001 << REQ_CAPTURE_CH7) |
    (32'h0000_0001 << REQ_CAPTURE_CH8) | (32'h0000_0001 << REQ_EXT_IRQ_TWO);

endpackage

/* inc/ivc_arb_if.sv */
// Purpose: Carries pending requests and the arbitration result
// Assumes: Arbiter is purely combinational
// Notes: One modport per side
`timescale 1ns/10ps
`default_nettype none
interface ivc_arb_if
  import ivc_pkg::*;
#(
  parameter int N = NUM_REQ
);
  logic [N-1:0] pending;
  logic [N-1:0][LVL_W-1:0] prio;
  logic win_valid;
  logic [$clog2(N)-1:0] win_idx;
  logic [LVL_W-1:0] win_level;

  modport arb (input pending, input prio, output win_valid, output win_idx, output win_level);
  modport ctl (output pending, output prio, input win_valid, input win_idx, input win_level);
endinterface
`default_nettype wire

/* src/ivc_arbiter.sv */
// Purpose: Picks the highest user level, lowest request number on a tie
// Assumes: Level zero means the source never requests
// Notes: Combinational only
`timescale 1ns/10ps
`default_nettype none
module ivc_arbiter
  import ivc_pkg::*;
#(
  parameter int N = NUM_REQ
) (
  // Request side and result
  ivc_arb_if.arb arb
);

  // Scan from the top down so a lower number wins on equal level
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx = '0;
    arb.win_level = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (arb.pending[i] && (arb.prio[i] != '0) && (!arb.win_valid || (arb.prio[i] >= arb.win_level))) begin
        arb.win_valid = 1'b1;
        arb.win_idx = i[$clog2(N)-1:0];
        arb.win_level = arb.prio[i];
      end
    end
  end

endmodule // ivc_arbiter
`default_nettype wire

/* src/ivc_vector_addr.sv */
// Purpose: Turns a vector number into its table entry address
// Assumes: Entries are two program words apart
// Notes: Alternate table sits a fixed distance above the primary one
`timescale 1ns/10ps
`default_nettype none
module ivc_vector_addr
  import ivc_pkg::*;
(
  // Selection
  input wire logic [VEC_W-1:0] vec_num,
  input wire logic alt_sel,
  // Entry address
  output logic [ADDR_W-1:0] entry_addr
);

  // Base plus two per vector, plus the alternate offset when selected
  always_comb begin
    entry_addr = TABLE_BASE + {{(ADDR_W-VEC_W-1){1'b0}}, vec_num, 1'b0};
    if (alt_sel) begin
      entry_addr = entry_addr + ALT_OFFSET;
    end
  end

endmodule // ivc_vector_addr
`default_nettype wire

/* sim/ivc_properties.sv */
// Purpose: Port-level checks of the interrupt vector controller
// Assumes: Bound to every instance of the controller top
// Notes: Entry address low byte checked; bit 8 follows the table select
`timescale 1ns/10ps
`default_nettype none
module ivc_properties
  import ivc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic cpu_irq_ack,
  input wire logic cpu_irq_req,
  input wire logic [VEC_W-1:0] cpu_vector_num,
  input wire logic [ADDR_W-1:0] cpu_vector_addr,
  input wire logic [CPU_LVL_W-1:0] cpu_irq_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // APB answer comes in the first access cycle and lasts one cycle
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access");
  // Presented request fields
  chk_entry_addr: assert property (cpu_irq_req |->
    cpu_vector_addr[7:0] == 8'h04 + {cpu_vector_num, 1'b0} && cpu_vector_addr[23:9] == '0)
    else $error("entry address does not match vector");
  chk_trap_level: assert property (cpu_irq_req && cpu_vector_num < 7'h08 |->
    cpu_vector_num != 7'h00 && cpu_irq_level == 4'hf - cpu_vector_num[3:0])
    else $error("trap level wrong");
  chk_user_level: assert property (cpu_irq_req && cpu_vector_num >= 7'h08 |->
    !cpu_irq_level[3] && cpu_irq_level != 4'h0)
    else $error("user level out of range");
  chk_impl_vec: assert property (cpu_irq_req && cpu_vector_num >= 7'h08 |->
    cpu_vector_num < 7'h28 && IMPL_MASK[cpu_vector_num - 7'h08])
    else $error("reserved vector requested");
  chk_ack_drop: assert property (cpu_irq_req && cpu_irq_ack |=> !cpu_irq_req)
    else $error("request stays after ack");
endmodule // ivc_properties

bind ivc_top ivc_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cpu_irq_ack(cpu_irq_ack), .cpu_irq_req(cpu_irq_req),
  .cpu_vector_num(cpu_vector_num), .cpu_vector_addr(cpu_vector_addr), .cpu_irq_level(cpu_irq_level));
`default_nettype wire

/* sim/ivc_core_model.sv */
// Purpose: Processor core stand-in that takes and returns from requests
// Assumes: Acks only while allowed and after a programmable wait
// Notes: Return is held until the bench has cleared the source flag
`timescale 1ns/10ps
`default_nettype none
module ivc_core_model
  import ivc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the bench
  input wire logic take,
  input wire logic [3:0] ack_wait,
  input wire logic ret_go,
  // Controller side
  input wire logic cpu_irq_req,
  output logic cpu_irq_ack,
  output logic cpu_irq_return
);
  logic [3:0] cnt_reg;
  logic busy_reg;

  // Ack a request after the wait, return when told
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      cpu_irq_ack <= 1'b0;
      cpu_irq_return <= 1'b0;
    end else begin
      cpu_irq_ack <= 1'b0;
      cpu_irq_return <= 1'b0;
      cnt_reg <= 4'h0;
      if (!busy_reg && take && cpu_irq_req && !cpu_irq_ack) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == ack_wait) begin
          cpu_irq_ack <= 1'b1;
          busy_reg <= 1'b1;
        end
      end else if (busy_reg && ret_go) begin
        cpu_irq_return <= 1'b1;
        busy_reg <= 1'b0;
      end
    end
  end
endmodule // ivc_core_model
`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench of the interrupt vector controller
// Assumes: Zero-wait APB slave, core stand-in acks and returns
// Notes: Winner is predicted from integer levels and a pending table
`timescale 1ns/10ps
`default_nettype none
module tb
  import ivc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, take = 1'b0, ret_go = 1'b0, err;
  logic [31:0] pwdata = '0, prdata, rd, w;
  logic pready, pslverr, ack, ret, req;
  logic [NUM_REQ-1:0] evt = '0;
  logic [2:0] ext = '0;
  logic [NUM_TRAP-1:0] trap = '0;
  logic [3:0] ack_wait = '0;
  logic [VEC_W-1:0] vec;
  logic [ADDR_W-1:0] vaddr;
  logic [CPU_LVL_W-1:0] lvl;
  int mismatches = 0, total_checks = 0, cycles = 0, seed = 32'h0000_f54e;
  int plvl[32], pend[40], alt, best, blvl;

  always #2 pclk = ~pclk;

  ivc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq_evt(evt), .ext_irq_zero(ext[0]), .ext_irq_one(ext[1]), .ext_irq_two(ext[2]),
    .trap_evt(trap), .cpu_irq_ack(ack), .cpu_irq_return(ret), .cpu_irq_req(req),
    .cpu_vector_num(vec), .cpu_vector_addr(vaddr), .cpu_irq_level(lvl));
  ivc_core_model core (.pclk(pclk), .presetn(presetn), .take(take), .ack_wait(ack_wait),
    .ret_go(ret_go), .cpu_irq_req(req), .cpu_irq_ack(ack), .cpu_irq_return(ret));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [APB_AW-1:0] a, input logic wr, input logic [31:0] d);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup does not reassign psel in this step
    @(posedge pclk);
  endtask

  // Highest level wins, lowest vector on a tie; traps sit above every user level
  function automatic void pick();
    int l;
    best = -1;
    blvl = 0;
    for (int v = 1; v < 40; v++) begin
      l = (v < 8) ? 15 - v : plvl[v-8];
      if (pend[v] != 0 && l > blvl) begin
        best = v;
        blvl = l;
      end
    end
  endfunction

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then an unmapped place
    for (int r = 0; r < 10; r++) begin
      apb(12'(r * 4), 1'b0, '0);
      check(rd, '0);
    end
    apb(12'h028, 1'b0, '0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(OFS_ENABLE, 1'b1, 32'hffff_ffff);
    apb(OFS_ENABLE, 1'b0, '0);
    check(rd, IMPL_MASK);
    apb(OFS_CPU_LEVEL, 1'b1, 32'h0000_000f);
    apb(OFS_CPU_LEVEL, 1'b0, '0);
    check(rd, 32'h0000_0007);
    apb(OFS_CPU_LEVEL, 1'b1, '0);
    for (int k = 0; k < 6; k++) begin
      // Table select and random levels
      alt = k % 2;
      apb(OFS_CONTROL, 1'b1, 32'(alt) << CTRL_ALT_BIT);
      for (int r = 0; r < 4; r++) begin
        w = $random(seed);
        apb(OFS_PRIO0 + 12'(r * 4), 1'b1, w);
        for (int j = 0; j < 8; j++) plvl[8*r+j] = int'(w[4*j +: 3]);
      end
      // Random events, traps and pin edges
      w = $random(seed);
      evt <= w;
      trap <= (k >= 4) ? w[3:0] : 4'h0;
      ext <= w[10:8];
      for (int r = 0; r < 32; r++) if (w[r] && IMPL_MASK[r]) pend[r+8] = 1;
      for (int t = 0; t < 4; t++) if (k >= 4 && w[t]) pend[t+1] = 1;
      if (w[8]) pend[8] = 1;
      if (w[9]) pend[28] = 1;
      if (w[10]) pend[37] = 1;
      @(posedge pclk);
      evt <= '0;
      trap <= '0;
      repeat (5) @(posedge pclk);
      ext <= '0;
      repeat (5) @(posedge pclk);
      apb(OFS_FLAG, 1'b0, '0);
      for (int r = 0; r < 32; r++) w[r] = (pend[r+8] != 0);
      check(rd, w);
      take <= 1'b1;
      // Serve every live request in predicted order
      forever begin
        pick();
        if (best < 0) break;
        ack_wait <= 4'($random(seed));
        do @(posedge pclk); while (!(ack === 1'b1 && req === 1'b1));
        check(32'(vec), 32'(best));
        check(32'(vaddr), 32'(TABLE_BASE + 24'(2 * best) + (alt != 0 ? ALT_OFFSET : 24'h00_0000)));
        check(32'(lvl), 32'(blvl));
        apb(OFS_STATUS, 1'b0, '0);
        check(rd, (32'(blvl) << ST_LVL_LSB) | 32'(best));
        if (best < 8) apb(OFS_TRAP, 1'b1, 32'h0000_0001 << (best - 1));
        else apb(OFS_FLAG, 1'b1, 32'h0000_0001 << (best - 8));
        pend[best] = 0;
        ret_go <= 1'b1;
        @(posedge pclk);
        ret_go <= 1'b0;
        @(posedge pclk);
      end
      take <= 1'b0;
      repeat (4) @(posedge pclk);
      check(32'(req), '0);
      apb(OFS_CPU_LEVEL, 1'b0, '0);
      check(rd, '0);
    end
    finish_test();
  end
endmodule // tb
`default_nettype wire
